//--- src/bsi_params.svh
`ifndef BSI_PARAMS_SVH
`define BSI_PARAMS_SVH
// instruction opcodes
`define BSI_OP_SAMPLE 4'h2
`define BSI_OP_DEVRST 4'hC
`define BSI_OP_BYPASS 4'hF
`define BSI_IR_W 4
// register map
`define BSI_MCU_CONTROL_ADDR 8'h35
`define BSI_MCU_CONTROL_RST 8'h00
`define BSI_DISABLE_BIT 7
// writable bits of the control register (bits 7, 4, 1, 0)
`define BSI_MCU_CONTROL_WMASK 8'h93
// timed sequence window in system clock cycles
`define BSI_TIMED_WIN 3'd4
// boundary chain length
`define BSI_CHAIN_W 8
`endif

//--- src/bsi_pkg.sv
package bsi_pkg;
   typedef enum logic [1:0] {
      BSI_SEL_BYPASS,
      BSI_SEL_CHAIN,
      BSI_SEL_RESET
   } bsi_sel_e;
endpackage

//--- src/bsi_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage sync; a change counts once stages two and three agree
module bsi_pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // pins
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               s1_r[g] <= 1'b0;
               s2_r[g] <= 1'b0;
               s3_r[g] <= 1'b0;
               q_o[g] <= 1'b0;
            end else begin
               s1_r[g] <= d_i[g];
               s2_r[g] <= s1_r[g];
               s3_r[g] <= s2_r[g];
               if (s2_r[g] == s3_r[g]) begin
                  q_o[g] <= s3_r[g];
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

//--- src/bsi_top.sv
`include "bsi_params.svh"
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - opcode 0x2 selects boundary chain, system undisturbed
// - sample/preload capture loads pin levels
// - sample/preload shift moves chain per TCK
// - update fills latches, latches never drive pins
// - opcode 0xC selects one-bit reset register
// - reset instruction never resets TAP controller
// - system reset held while reset bit is one and port enabled
// - reset bit drives reset request unlatched
// - reset bit shifts TDI toward TDO
// - opcode 0xF selects one-stage bypass register
// - bypass capture loads zero
// - bypass cell shifts TDI, old value to TDO
// - port enabled when bit7 clear and fuse set
// - disable bit changes on two matching writes at most four cycles apart
// - instruction register is four bits wide
// - all shifting is least significant bit first
module bsi_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // test port pins
   input wire logic tck_i,
   input wire logic tdi_i,
   output logic tdo_o,
   output logic tdo_oe_b_o,
   // tap controller state, from tap logic on tck
   input wire logic [`BSI_IR_W-1:0] instr_i,
   input wire logic capture_dr_i,
   input wire logic shift_dr_i,
   input wire logic update_dr_i,
   // fuse and pins observed by the chain
   input wire logic test_port_enable_fuse_i,
   input wire logic [`BSI_CHAIN_W-1:0] pins_i,
   // io memory access
   input wire logic [7:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic [7:0] io_wdata_i,
   output logic [7:0] io_rdata_o,
   // status out
   output logic test_port_en_o,
   output logic device_reset_req_o,
   output logic [`BSI_CHAIN_W-1:0] out_latch_o
);
   logic tck_s;
   logic tdi_s;
   logic cap_s;
   logic sft_s;
   logic upd_s;
   logic [`BSI_IR_W-1:0] ir_s;
   logic [`BSI_CHAIN_W-1:0] pin_s;
   logic tck_d_r;
   logic tck_rise;
   logic tck_fall;
   bsi_pkg::bsi_sel_e sel;
   logic [`BSI_CHAIN_W-1:0] chain_r;
   logic bypass_r;
   logic reset_bit_r;
   logic dr_out;
   logic [7:0] mcu_control_r;
   logic [2:0] win_cnt_r;
   logic pend_val_r;
   logic en;
   logic ctl_wr;
   logic [7:0] wdata_m;

   bsi_pin_sync #(
      .W(`BSI_IR_W + `BSI_CHAIN_W + 5)
   ) u_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .d_i({tck_i, tdi_i, capture_dr_i, shift_dr_i, update_dr_i,
            instr_i, pins_i}),
      .q_o({tck_s, tdi_s, cap_s, sft_s, upd_s, ir_s, pin_s})
   );

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tck_d_r <= 1'b0;
      end else begin
         tck_d_r <= tck_s;
      end
   end
   assign tck_rise = tck_s & ~tck_d_r;
   assign tck_fall = ~tck_s & tck_d_r;

   // the 4-bit opcode picks the data path
   always_comb begin
      case (ir_s)
         `BSI_OP_SAMPLE: sel = bsi_pkg::BSI_SEL_CHAIN;
         `BSI_OP_DEVRST: sel = bsi_pkg::BSI_SEL_RESET;
         `BSI_OP_BYPASS: sel = bsi_pkg::BSI_SEL_BYPASS;
         default: sel = bsi_pkg::BSI_SEL_BYPASS;
      endcase
   end

   // boundary chain; shifts toward bit 0, lsb out first
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         chain_r <= '0;
      end else if (en && tck_rise && sel == bsi_pkg::BSI_SEL_CHAIN) begin
         if (cap_s) begin
            chain_r <= pin_s;
         end else if (sft_s) begin
            chain_r <= {tdi_s, chain_r[`BSI_CHAIN_W-1:1]};
         end
      end
   end

   // latches only; never routed to pads here
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_latch_o <= '0;
      end else if (en && tck_fall && upd_s &&
                   sel == bsi_pkg::BSI_SEL_CHAIN) begin
         out_latch_o <= chain_r;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bypass_r <= 1'b0;
      end else if (en && tck_rise && sel == bsi_pkg::BSI_SEL_BYPASS) begin
         if (cap_s) begin
            bypass_r <= 1'b0;
         end else if (sft_s) begin
            bypass_r <= tdi_s;
         end
      end
   end

   // only the reset bit; tap state lives elsewhere and is untouched
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reset_bit_r <= 1'b0;
      end else if (en && tck_rise && sft_s &&
                   sel == bsi_pkg::BSI_SEL_RESET) begin
         reset_bit_r <= tdi_s;
      end
   end

   // no update stage on purpose: reset tracks the bit
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         device_reset_req_o <= 1'b0;
      end else begin
         device_reset_req_o <= en & reset_bit_r;
      end
   end

   always_comb begin
      case (sel)
         bsi_pkg::BSI_SEL_CHAIN: dr_out = chain_r[0];
         bsi_pkg::BSI_SEL_RESET: dr_out = reset_bit_r;
         default: dr_out = bypass_r;
      endcase
   end

   // tdo moves only on falling tck edges in shift; held when released
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tdo_o <= 1'b0;
         tdo_oe_b_o <= 1'b1;
      end else if (!en) begin
         tdo_oe_b_o <= 1'b1;
      end else if (tck_fall) begin
         tdo_oe_b_o <= ~sft_s;
         if (sft_s) begin
            tdo_o <= dr_out;
         end
      end
   end

   assign en = test_port_enable_fuse_i &
               ~mcu_control_r[`BSI_DISABLE_BIT];
   assign ctl_wr = io_wr_i && io_addr_i == `BSI_MCU_CONTROL_ADDR;
   assign wdata_m = io_wdata_i & `BSI_MCU_CONTROL_WMASK;

   // timed sequence guards the disable bit
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         win_cnt_r <= 3'd0;
         pend_val_r <= 1'b0;
      end else if (ctl_wr && (win_cnt_r == 3'd0 ||
                   io_wdata_i[`BSI_DISABLE_BIT] != pend_val_r)) begin
         win_cnt_r <= `BSI_TIMED_WIN;
         pend_val_r <= io_wdata_i[`BSI_DISABLE_BIT];
      end else if (ctl_wr) begin
         win_cnt_r <= 3'd0;
      end else if (win_cnt_r != 3'd0) begin
         win_cnt_r <= win_cnt_r - 3'd1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mcu_control_r <= `BSI_MCU_CONTROL_RST;
      end else if (ctl_wr) begin
         mcu_control_r[6:0] <= wdata_m[6:0];
         if (win_cnt_r != 3'd0 &&
             io_wdata_i[`BSI_DISABLE_BIT] == pend_val_r) begin
            mcu_control_r[`BSI_DISABLE_BIT] <= pend_val_r;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         io_rdata_o <= 8'h00;
         test_port_en_o <= 1'b0;
      end else begin
         io_rdata_o <= (io_addr_i == `BSI_MCU_CONTROL_ADDR) ?
                       mcu_control_r : 8'h00;
         test_port_en_o <= en;
      end
   end
endmodule
`default_nettype wire

//--- tb/bsi_top_asserts.sv
`include "bsi_params.svh"
`timescale 1ns/1ps
`default_nettype none
module bsi_top_asserts (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // watched ports
   input wire logic shift_dr_i,
   input wire logic update_dr_i,
   input wire logic test_port_enable_fuse_i,
   input wire logic [7:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic [7:0] io_rdata_o,
   input wire logic tdo_o,
   input wire logic tdo_oe_b_o,
   input wire logic test_port_en_o,
   input wire logic device_reset_req_o,
   input wire logic [`BSI_CHAIN_W-1:0] out_latch_o
);
   // eight clocks of history outlast every sync delay
   logic [7:0] wr_h, sh_h, up_h;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {wr_h, sh_h, up_h} <= 24'h00_0000;
      end else begin
         wr_h <= {wr_h[6:0], io_wr_i && io_addr_i == 8'h35};
         sh_h <= {sh_h[6:0], shift_dr_i};
         up_h <= {up_h[6:0], update_dr_i};
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   sequence s_off2;
      !test_port_en_o [*2];
   endsequence
   a_oe_when_en: assert property (
      !tdo_oe_b_o |-> test_port_en_o) else $error("tdo driven when off");
   a_fuse_gate: assert property (
      !test_port_enable_fuse_i |=> !test_port_en_o) else $error("fuse");
   a_rst_when_off: assert property (
      s_off2 |-> !device_reset_req_o) else $error("reset when off");
   a_disable_pair: assert property (
      $fell(test_port_en_o) && test_port_enable_fuse_i
      && $past(test_port_enable_fuse_i, 2) |-> $countones(wr_h) >= 2)
      else $error("disable without two writes");
   a_rsvd_zero: assert property (
      io_addr_i == 8'h35 |=> (io_rdata_o & 8'h6C) == 8'h00)
      else $error("reserved bits set");
   a_rst_by_shift: assert property (
      $changed(device_reset_req_o) |-> sh_h != 8'h00 || !test_port_en_o)
      else $error("reset moved without shift");
   a_latch_by_upd: assert property (
      $changed(out_latch_o) |-> up_h != 8'h00) else $error("latch moved");
   a_tdo_by_shift: assert property (
      $changed(tdo_o) |-> sh_h != 8'h00 || !test_port_en_o)
      else $error("tdo moved without shift");
endmodule
bind bsi_top bsi_top_asserts i_bsi_top_asserts (.clk_i, .rst_b_i,
   .shift_dr_i, .update_dr_i, .test_port_enable_fuse_i, .io_addr_i,
   .io_wr_i, .io_rdata_o, .tdo_o, .tdo_oe_b_o, .test_port_en_o,
   .device_reset_req_o, .out_latch_o);
`default_nettype wire

//--- tb/bsi_tap_model.sv
`timescale 1ns/1ps
`default_nettype none
// outside test controller; tck rests low between frames
module bsi_tap_model (
   // tap lines
   output logic tck_o,
   output logic tdi_o,
   output logic [3:0] instr_o,
   output logic cap_o,
   output logic shift_o,
   output logic upd_o,
   // return
   input wire logic tdo_i
);
   initial {tck_o, tdi_o, cap_o, shift_o, upd_o, instr_o} = 9'h00F;
   task automatic tick(input logic c, input logic s, input logic u);
      tck_o = 1'b1;
      #40;
      {cap_o, shift_o, upd_o} = {c, s, u};
      #22.5;
      tck_o = 1'b0;
      // stale data shows its inverse
      tdi_o = ~tdi_o;
      #32.5;
   endtask
   task automatic scan(input logic [3:0] op, input int n,
      input logic [7:0] d, output logic [7:0] q);
      q = 8'h00;
      instr_o = op;
      cap_o = 1'b1;
      // keeps every pin change clear of the system clock edges
      #61.25;
      tick(1'b0, 1'b1, 1'b0);
      for (int i = 0; i < n; i++) begin
         tdi_o = d[i];
         #30;
         q[i] = tdo_i;
         tick(1'b0, i < n - 1, 1'b0);
      end
      tick(1'b0, 1'b0, 1'b1);
      tick(1'b0, 1'b0, 1'b0);
      // back on a falling clock edge for the next caller
      #3.75;
   endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
`include "bsi_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic fuse = 1'b1;
   logic wr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wd = 8'h00;
   logic [7:0] pins = 8'h2D;
   logic tck, tdi, cap, shf, upd, tdo, oe_b, en, rq;
   logic [3:0] ins;
   logic [7:0] rd, q, lat;
   logic [3:0] ops [3] = '{`BSI_OP_BYPASS, 4'h5, 4'hA};
   int miscompares = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #2.5 clk_i = ~clk_i;
   bsi_tap_model i_bsi_tap_model (.tck_o(tck), .tdi_o(tdi), .instr_o(ins),
      .cap_o(cap), .shift_o(shf), .upd_o(upd), .tdo_i(tdo));
   bsi_top i_bsi_top (.clk_i, .rst_b_i, .tck_i(tck), .tdi_i(tdi),
      .tdo_o(tdo), .tdo_oe_b_o(oe_b), .instr_i(ins), .capture_dr_i(cap),
      .shift_dr_i(shf), .update_dr_i(upd), .test_port_enable_fuse_i(fuse),
      .pins_i(pins), .io_addr_i(addr), .io_wr_i(wr), .io_wdata_i(wd),
      .io_rdata_o(rd), .test_port_en_o(en), .device_reset_req_o(rq),
      .out_latch_o(lat));
   task automatic chk(input string s, input logic [7:0] e,
      input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr_io(input logic [7:0] d);
      @(negedge clk_i);
      {addr, wd, wr} = {8'h35, d, 1'b1};
      @(negedge clk_i);
      wr = 1'b0;
   endtask
   task automatic rd_io(input logic [7:0] a, input logic [7:0] e,
      input string s);
      @(negedge clk_i);
      addr = a;
      @(negedge clk_i);
      chk(s, e, rd);
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // scans take about two thousand clocks in all
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         finish_test();
      end
   end
   initial begin
      repeat (8) @(negedge clk_i);
      rst_b_i = 1'b1;
      rd_io(8'h35, 8'h00, "control reset");
      chk("port on", 8'h01, {7'h00, en});
      wr_io(8'hFF);
      rd_io(8'h35, 8'h13, "single write");
      rd_io(8'h40, 8'h00, "unmapped");
      // second write five cycles on: one past the window
      wr_io(8'h80);
      repeat (3) @(negedge clk_i);
      wr_io(8'h80);
      repeat (6) @(negedge clk_i);
      rd_io(8'h35, 8'h00, "expired window");
      // second write four cycles on: last accepted cycle
      wr_io(8'h80);
      repeat (2) @(negedge clk_i);
      wr_io(8'h80);
      rd_io(8'h35, 8'h80, "timed disable");
      chk("port off", 8'h00, {7'h00, en});
      i_bsi_tap_model.scan(`BSI_OP_DEVRST, 1, 8'h01, q);
      chk("reset when off", 8'h00, {7'h00, rq});
      chk("tdo released", 8'h01, {7'h00, oe_b});
      wr_io(8'h00);
      wr_io(8'h00);
      fuse = 1'b0;
      repeat (3) @(negedge clk_i);
      chk("fuse off", 8'h00, {7'h00, en});
      fuse = 1'b1;
      repeat (3) @(negedge clk_i);
      chk("port back", 8'h01, {7'h00, en});
      foreach (ops[k]) begin
         i_bsi_tap_model.scan(ops[k], 8, 8'hB4, q);
         chk("bypass", 8'h68, q);
      end
      i_bsi_tap_model.scan(`BSI_OP_SAMPLE, 8, 8'hC3, q);
      chk("pin snapshot", 8'h2D, q);
      chk("update latch", 8'hC3, lat);
      pins = 8'h96;
      i_bsi_tap_model.scan(`BSI_OP_SAMPLE, 8, 8'h5A, q);
      chk("pin snapshot 2", 8'h96, q);
      chk("update latch 2", 8'h5A, lat);
      i_bsi_tap_model.scan(`BSI_OP_DEVRST, 1, 8'h01, q);
      chk("reset held", 8'h01, {7'h00, rq});
      i_bsi_tap_model.scan(`BSI_OP_BYPASS, 8, 8'hB4, q);
      chk("tap alive", 8'h68, q);
      chk("reset kept", 8'h01, {7'h00, rq});
      i_bsi_tap_model.scan(`BSI_OP_DEVRST, 1, 8'h00, q);
      chk("reset bit out", 8'h01, q);
      chk("reset gone", 8'h00, {7'h00, rq});
      // idle port left disabled
      wr_io(8'h80);
      wr_io(8'h80);
      finish_test();
   end
endmodule
`default_nettype wire
